// file: design/expander_target.sv
// Serial-controlled 8-bit port expander: register layer, pins and change alert.
// How it works
// - Master reads: write address, selector, restart, read.
// - After read address, expander drives data on SDA.
// - Master acks bytes, nacks the last, then stops.
// - Bus address 0x20 with strap low, 0x21 high.
// - Address byte LSB: one reads, zero writes.
// - First byte after write address is command.
// - Command values 0 to 3 select input, latch, invert, direction.
// - Command pointer is writable; reads return it only when it selects no register.
// - Input register returns live pin levels flipped by invert.
// - Writes to input register acked, then discarded.
// - Selected register persists across transfers.
// - STOP anywhere; data acked so far stays valid.
// - Latch drives only output pins; resets to ones.
// - Latch reads return flip-flops, not pin levels.
// - Invert bit flips sensed input; resets to zero.
// - Direction one means input, zero output; resets ones.
// - Input pin edges assert the alert; outputs never.
// - Alert clears on return or input register read.
// - Reset low returns registers and bus logic to defaults.
//
// Design decision made here: the APB register port.
module expander_target (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial link
    expander_link_if.target link,
    // Expander pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    // Strap and alert
    input wire logic addr_strap,
    output logic alert_n
);
    typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} slave_state_t;
    typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} byte_kind_t;

    logic [1:0] line_q;
    logic [7:0] pin_q;
    logic strap_q;
    logic scl_prev_r;
    logic sda_prev_r;
    slave_state_t state_r;
    byte_kind_t kind_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic reading_r;
    logic mack_r;
    logic sda_oe_n_r;
    logic sda_o_r;
    logic [7:0] ptr_r;
    logic [7:0] invert_r;
    logic [7:0] captured_r;
    logic [1:0] fill_r;

    sync2 #(.WIDTH(2), .INIT(2'h3)) u_line_sync (.pclk(pclk), .presetn(presetn), .d({link.scl, link.sda}), .q(line_q));
    sync2 #(.WIDTH(8), .INIT(8'h00)) u_pin_sync (.pclk(pclk), .presetn(presetn), .d(pin_in), .q(pin_q));
    sync2 #(.WIDTH(1), .INIT(1'b0)) u_strap_sync (.pclk(pclk), .presetn(presetn), .d(addr_strap), .q(strap_q));

    function automatic logic [7:0] read_value(input logic [7:0] ptr, input logic [7:0] pins,
                                              input logic [7:0] inv, input logic [7:0] latch,
                                              input logic [7:0] dir);
        logic [7:0] v;
        v = ptr;
        case (ptr)
            expander_pkg::PTR_INPUT: v = pins ^ inv;
            expander_pkg::PTR_LATCH: v = latch;
            expander_pkg::PTR_INVERT: v = inv;
            expander_pkg::PTR_DIR: v = dir;
            default: v = ptr;
        endcase
        return v;
    endfunction

    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_hit;
    logic byte_done;
    logic wr_event;
    logic rd_clear;
    logic [7:0] tx_byte;

    assign scl_q = line_q[1];
    assign sda_q = line_q[0];
    assign scl_rise = scl_q & ~scl_prev_r;
    assign scl_fall = ~scl_q & scl_prev_r;
    assign start_cond = scl_q & scl_prev_r & sda_prev_r & ~sda_q;
    assign stop_cond = scl_q & scl_prev_r & ~sda_prev_r & sda_q;
    assign addr_hit = shift_r[7:1] == (expander_pkg::BUS_ADDR_BASE | {6'h00, strap_q});
    assign byte_done = (state_r == S_RX) && scl_fall && (bit_cnt_r == 4'h8) && !start_cond && !stop_cond;
    assign wr_event = byte_done && (kind_r != K_ADDR);
    // The alert is cleared at the master's acknowledge clock of an input register read.
    assign rd_clear = (state_r == S_TX_ACK) && scl_rise && (ptr_r == expander_pkg::PTR_INPUT);
    assign tx_byte = read_value(ptr_r, pin_q, invert_r, pin_out, pin_oe_n);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else
        begin
            scl_prev_r <= scl_q;
            sda_prev_r <= sda_q;
        end
    end

    // Bus state machine. A start or stop wins over any bit in progress.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= S_IDLE;
            kind_r <= K_ADDR;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            reading_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
        end
        else if (start_cond)
        begin
            state_r <= S_RX;
            kind_r <= K_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end
        else if (stop_cond)
        begin
            state_r <= S_IDLE;
            sda_oe_n_r <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                S_IDLE:
                begin
                    sda_oe_n_r <= 1'b1;
                end
                S_RX:
                begin
                    if (scl_rise && bit_cnt_r != 4'h8)
                    begin
                        shift_r <= {shift_r[6:0], sda_q};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (kind_r != K_ADDR || addr_hit)
                        begin
                            // Every data byte is acked, even one that is then discarded.
                            sda_oe_n_r <= 1'b0;
                            state_r <= S_RX_ACK;
                            if (kind_r == K_ADDR)
                                reading_r <= shift_r[0] == expander_pkg::RW_READ;
                        end
                        else
                            state_r <= S_IDLE;
                    end
                end
                S_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (kind_r == K_ADDR && reading_r)
                        begin
                            // No command byte in a read: data comes from the held pointer.
                            shift_r <= tx_byte;
                            sda_oe_n_r <= tx_byte[7];
                            state_r <= S_TX;
                        end
                        else
                        begin
                            sda_oe_n_r <= 1'b1;
                            kind_r <= (kind_r == K_ADDR) ? K_CMD : K_DATA;
                            state_r <= S_RX;
                        end
                    end
                end
                S_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == 4'h7)
                        begin
                            sda_oe_n_r <= 1'b1;
                            state_r <= S_TX_ACK;
                        end
                        else
                        begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe_n_r <= shift_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                S_TX_ACK:
                begin
                    if (scl_rise)
                        mack_r <= ~sda_q;
                    else if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r)
                        begin
                            shift_r <= tx_byte;
                            sda_oe_n_r <= tx_byte[7];
                            state_r <= S_TX;
                        end
                        else
                            state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Register file; a byte counts once its acknowledge begins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_r <= expander_pkg::POINTER_RESET;
            pin_out <= expander_pkg::LATCH_RESET;
            invert_r <= expander_pkg::INVERT_RESET;
            pin_oe_n <= expander_pkg::DIR_RESET;
        end
        else if (wr_event)
        begin
            if (kind_r == K_CMD)
                ptr_r <= shift_r;
            else
            begin
                case (ptr_r)
                    expander_pkg::PTR_LATCH: pin_out <= shift_r;
                    expander_pkg::PTR_INVERT: invert_r <= shift_r;
                    // A direction bit of one releases the driver, so it serves directly as the active-low enable.
                    expander_pkg::PTR_DIR: pin_oe_n <= shift_r;
                    default: ptr_r <= ptr_r;
                endcase
            end
        end
    end

    // Change alert. The pin synchroniser still shows its reset value for two edges after release,
    // so the reference is taken again until the real levels have arrived; otherwise a pin held
    // high through reset would raise a false alert.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            captured_r <= 8'h00;
            fill_r <= 2'h0;
            alert_n <= 1'b1;
        end
        else if (fill_r != 2'h3)
        begin
            captured_r <= pin_q;
            fill_r <= fill_r + 2'h1;
            alert_n <= 1'b1;
        end
        else if (rd_clear)
        begin
            captured_r <= pin_q;
            alert_n <= 1'b1;
        end
        else
            alert_n <= ~(|((pin_q ^ captured_r) & pin_oe_n));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sda_o_r <= 1'b0;
        else
            sda_o_r <= 1'b0;
    end

    assign link.sda_s_o = sda_o_r;
    assign link.sda_s_oe_n = sda_oe_n_r;
endmodule

// file: design/expander_pkg.sv
// Shared constants and types for the serial port expander and its controller.
package expander_pkg;
    // Serial bus address: the strap level fills the lowest address bit.
    localparam logic [6:0] BUS_ADDR_BASE = 7'h20;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // Register selectors carried by the command byte.
    localparam logic [7:0] PTR_INPUT = 8'h00;
    localparam logic [7:0] PTR_LATCH = 8'h01;
    localparam logic [7:0] PTR_INVERT = 8'h02;
    localparam logic [7:0] PTR_DIR = 8'h03;

    // Values after reset.
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] INVERT_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    // Serial clock made by the controller from pclk.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 2500;
    localparam logic [7:0] QUARTER_COUNT = 8'(SCL_PERIOD_NS / 4 / CLK_PERIOD_NS);

    // Controller register offsets on APB.
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_WDATA = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;

    // Field positions.
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_READ_BIT = 7;
    localparam int CMD_BYTE_LSB = 8;
    localparam int CMD_USE_CMD_BIT = 16;
    localparam int CMD_USE_DATA_BIT = 17;
    localparam int CMD_GO_BIT = 31;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NACK_BIT = 1;
    localparam int STATUS_RDATA_LSB = 8;

    // Length of the longest transfer sequence.
    localparam int SEQ_LEN = 7;

    typedef enum logic [1:0] {OP_START, OP_SEND, OP_RECV, OP_STOP} link_op_t;
endpackage

// file: design/expander_link_if.sv
// Open-drain serial link joining the controller and the expander.
interface expander_link_if;
    logic scl_m_o;
    logic scl_m_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic scl;
    logic sda;

    // A released line floats high through the pull-up.
    assign scl = scl_m_oe_n | scl_m_o;
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

    modport master (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n, input scl, input sda);
    modport target (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface

// file: design/sync2.sv
// Two-flip-flop synchroniser for signals entering the pclk domain.
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: design/expander_controller.sv
// Serial bus controller for the expander, steered by software over APB.
module expander_controller (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    expander_link_if.master link
);
    typedef enum logic {H_IDLE, H_RUN} host_state_t;

    logic sda_q;
    logic [31:0] cmd_r;
    logic [7:0] wdata_r;
    logic [7:0] rdata_r;
    logic nack_r;
    host_state_t state_r;
    expander_pkg::link_op_t op_r [expander_pkg::SEQ_LEN];
    logic [7:0] byte_r [expander_pkg::SEQ_LEN];
    logic [2:0] nops_r;
    logic [2:0] step_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] qcnt_r;
    logic scl_oe_n_r;
    logic sda_oe_n_r;
    logic drive_r;

    sync2 #(.WIDTH(1), .INIT(1'b1)) u_sda_sync (.pclk(pclk), .presetn(presetn), .d(link.sda), .q(sda_q));

    logic access;
    logic mapped;
    logic write_fire;
    logic go;
    logic tick;
    expander_pkg::link_op_t op;
    expander_pkg::link_op_t seq_op [expander_pkg::SEQ_LEN];
    logic [7:0] seq_byte [expander_pkg::SEQ_LEN];
    logic [2:0] seq_len;

    assign access = psel && penable;
    assign mapped = paddr == expander_pkg::REG_CMD || paddr == expander_pkg::REG_WDATA
                    || paddr == expander_pkg::REG_STATUS;
    assign write_fire = access && pready && pwrite && mapped;
    assign go = write_fire && paddr == expander_pkg::REG_CMD && pwdata[expander_pkg::CMD_GO_BIT]
                && state_r == H_IDLE;
    assign tick = qcnt_r == expander_pkg::QUARTER_COUNT - 8'h01;
    assign op = op_r[step_r];

    // Build the transfer as a list of link operations.
    always_comb
    begin
        int n;
        logic rd;
        logic [6:0] addr;
        n = 0;
        rd = pwdata[expander_pkg::CMD_READ_BIT];
        addr = pwdata[expander_pkg::CMD_ADDR_LSB +: 7];
        for (int i = 0; i < expander_pkg::SEQ_LEN; i++)
        begin
            seq_op[i] = expander_pkg::OP_STOP;
            seq_byte[i] = 8'h00;
        end
        seq_op[n] = expander_pkg::OP_START;
        n++;
        if (!rd || pwdata[expander_pkg::CMD_USE_CMD_BIT])
        begin
            seq_op[n] = expander_pkg::OP_SEND;
            seq_byte[n] = {addr, expander_pkg::RW_WRITE};
            n++;
        end
        if (pwdata[expander_pkg::CMD_USE_CMD_BIT])
        begin
            seq_op[n] = expander_pkg::OP_SEND;
            seq_byte[n] = pwdata[expander_pkg::CMD_BYTE_LSB +: 8];
            n++;
        end
        if (rd)
        begin
            if (pwdata[expander_pkg::CMD_USE_CMD_BIT])
            begin
                seq_op[n] = expander_pkg::OP_START;
                n++;
            end
            seq_op[n] = expander_pkg::OP_SEND;
            seq_byte[n] = {addr, expander_pkg::RW_READ};
            n++;
            seq_op[n] = expander_pkg::OP_RECV;
            n++;
        end
        else if (pwdata[expander_pkg::CMD_USE_DATA_BIT])
        begin
            seq_op[n] = expander_pkg::OP_SEND;
            seq_byte[n] = wdata_r;
            n++;
        end
        seq_op[n] = expander_pkg::OP_STOP;
        n++;
        seq_len = 3'(n);
    end

    // APB answers with one wait state so that read data leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (access && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            case (paddr)
                expander_pkg::REG_CMD: prdata <= {1'b0, cmd_r[30:0]};
                expander_pkg::REG_WDATA: prdata <= {24'h000000, wdata_r};
                expander_pkg::REG_STATUS: prdata <= {16'h0000, rdata_r, 6'h00, nack_r, state_r == H_RUN};
                default: prdata <= 32'h00000000;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r <= 32'h00000000;
            wdata_r <= 8'h00;
        end
        else if (write_fire)
        begin
            if (paddr == expander_pkg::REG_CMD && state_r == H_IDLE)
                cmd_r <= pwdata;
            if (paddr == expander_pkg::REG_WDATA)
                wdata_r <= pwdata[7:0];
        end
    end

    // Link engine: each bit is four quarters of the serial clock period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= H_IDLE;
            nops_r <= 3'h0;
            step_r <= 3'h0;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            qcnt_r <= 8'h00;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            rdata_r <= 8'h00;
            nack_r <= 1'b0;
            for (int i = 0; i < expander_pkg::SEQ_LEN; i++)
            begin
                op_r[i] <= expander_pkg::OP_STOP;
                byte_r[i] <= 8'h00;
            end
        end
        else if (go)
        begin
            state_r <= H_RUN;
            op_r <= seq_op;
            byte_r <= seq_byte;
            nops_r <= seq_len;
            step_r <= 3'h0;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            qcnt_r <= 8'h00;
            nack_r <= 1'b0;
        end
        else if (state_r == H_RUN)
        begin
            qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
            if (tick)
            begin
                q_r <= q_r + 2'h1;
                unique case (op)
                    expander_pkg::OP_START:
                    begin
                        case (q_r)
                            2'h0: sda_oe_n_r <= 1'b1;
                            2'h1: scl_oe_n_r <= 1'b1;
                            2'h2: sda_oe_n_r <= 1'b0;
                            default:
                            begin
                                scl_oe_n_r <= 1'b0;
                                step_r <= step_r + 3'h1;
                            end
                        endcase
                    end
                    expander_pkg::OP_SEND, expander_pkg::OP_RECV:
                    begin
                        case (q_r)
                            // Receiving, the master releases SDA and answers the byte with a NACK.
                            2'h0: sda_oe_n_r <= (op == expander_pkg::OP_SEND && bit_r != 4'h8)
                                                ? byte_r[step_r][3'(4'h7 - bit_r)] : 1'b1;
                            2'h1: scl_oe_n_r <= 1'b1;
                            2'h2:
                            begin
                                if (op == expander_pkg::OP_RECV && bit_r != 4'h8)
                                    rdata_r <= {rdata_r[6:0], sda_q};
                                if (op == expander_pkg::OP_SEND && bit_r == 4'h8 && sda_q)
                                    nack_r <= 1'b1;
                            end
                            default:
                            begin
                                scl_oe_n_r <= 1'b0;
                                bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
                                // A refused byte ends the transfer at once with a STOP.
                                if (bit_r == 4'h8)
                                    step_r <= nack_r ? nops_r - 3'h1 : step_r + 3'h1;
                            end
                        endcase
                    end
                    expander_pkg::OP_STOP:
                    begin
                        case (q_r)
                            2'h0: sda_oe_n_r <= 1'b0;
                            2'h1: scl_oe_n_r <= 1'b1;
                            2'h2: sda_oe_n_r <= 1'b1;
                            default: state_r <= H_IDLE;
                        endcase
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive_r <= 1'b0;
        else
            drive_r <= 1'b0;
    end

    assign link.scl_m_o = drive_r;
    assign link.sda_m_o = drive_r;
    assign link.scl_m_oe_n = scl_oe_n_r;
    assign link.sda_m_oe_n = sda_oe_n_r;
endmodule

// file: tb/expander_link_chk.sv
// Wire-level checks on the serial link joining the controller and the expander.
module expander_link_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link signals
    input wire logic scl_m_o,
    input wire logic scl_m_oe_n,
    input wire logic sda_m_o,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_RST_REL: assert property ($rose(presetn) |-> scl_m_oe_n && sda_m_oe_n && sda_s_oe_n)
        else $error("link driven at reset release");
    AST_SCL_ZERO: assert property (!scl_m_oe_n |-> !scl_m_o)
        else $error("clock driven high");
    AST_MSDA_ZERO: assert property (!sda_m_oe_n |-> !sda_m_o)
        else $error("controller data driven high");
    AST_SSDA_ZERO: assert property (!sda_s_oe_n |-> !sda_s_o && !sda)
        else $error("expander data not low");
    AST_SDA_LOW_CLK: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("expander data moved with clock high");
    AST_SDA_HOLD: assert property ($fell(scl) |=> $stable(sda_s_oe_n) [*2])
        else $error("expander data moved too soon after clock fall");
    AST_STOP_FREE: assert property (scl && $rose(sda) |=> sda_s_oe_n [*4])
        else $error("expander holds data after stop");
    AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*8])
        else $error("clock high phase too short");
endmodule

// file: tb/tb_i2c_gpio_expander_regs.sv
// Bench: software drives the controller over APB, which talks to the expander.
module tb_i2c_gpio_expander_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, addr_strap = 1, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, st;
    logic pready, pslverr, alert_n;
    logic [7:0] pin_in = 8'h00, pin_out, pin_oe_n;
    int fails = 0, comparisons = 0;
    expander_link_if u_link ();
    expander_target u_expander_target (.pclk, .presetn, .link(u_link), .pin_in, .pin_out, .pin_oe_n, .addr_strap,
        .alert_n);
    expander_controller u_expander_controller (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .link(u_link));
    expander_link_chk u_expander_link_chk (.pclk, .presetn, .scl_m_o(u_link.scl_m_o), .scl_m_oe_n(u_link.scl_m_oe_n),
        .sda_m_o(u_link.sda_m_o), .sda_m_oe_n(u_link.sda_m_oe_n), .sda_s_o(u_link.sda_s_o),
        .sda_s_oe_n(u_link.sda_s_oe_n), .scl(u_link.scl), .sda(u_link.sda));
    always #4 pclk = ~pclk;
    task automatic complete_run;
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A lost answer counts as a mismatch and ends the run at once.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        fails += (pready !== 1'b1);
        if (pready !== 1'b1)
            complete_run();
        st = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] c, input logic [1:0] u, input logic [7:0] d);
        int n;
        apb(1'b1, expander_pkg::REG_WDATA, {24'h0, d});
        apb(1'b1, expander_pkg::REG_CMD, {1'b1, 13'h0, u, c, r, a});
        n = 0;
        do
        begin
            apb(1'b0, expander_pkg::REG_STATUS, 32'h0);
            n++;
        end while (st[0] !== 1'b0 && n < 9000);
        fails += (n >= 9000);
        if (n >= 9000)
            complete_run();
    endtask
    task automatic rd(input logic [7:0] c, input logic u, input logic [7:0] e);
        xfer(7'h21, 1'b1, c, {1'b0, u}, 8'h00);
        chk({st[15:8], st[1:0]}, {e, 2'b00});
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk({alert_n, pin_oe_n, pin_out}, {1'b1, expander_pkg::DIR_RESET, expander_pkg::LATCH_RESET});
        apb(1'b0, 12'h00C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(st, 32'h0);
        rd(expander_pkg::PTR_LATCH, 1'b1, 8'hFF);
        xfer(7'h21, 1'b0, expander_pkg::PTR_DIR, 2'b11, 8'h0F);
        xfer(7'h21, 1'b0, expander_pkg::PTR_LATCH, 2'b11, 8'hA5);
        chk({pin_oe_n, pin_out}, 16'h0FA5);
        xfer(7'h21, 1'b0, expander_pkg::PTR_INVERT, 2'b11, 8'h03);
        rd(8'h00, 1'b0, 8'h03);
        pin_in <= 8'h3C;
        rd(expander_pkg::PTR_INPUT, 1'b1, 8'h3F);
        pin_in <= 8'hBC;
        repeat (10) @(posedge pclk);
        chk(alert_n, 1'b1);
        pin_in <= 8'h3D;
        repeat (10) @(posedge pclk);
        chk(alert_n, 1'b0);
        pin_in <= 8'h3C;
        repeat (10) @(posedge pclk);
        chk(alert_n, 1'b1);
        pin_in <= 8'h3E;
        rd(8'h00, 1'b0, 8'h3D);
        chk(alert_n, 1'b1);
        xfer(7'h21, 1'b0, expander_pkg::PTR_INPUT, 2'b11, 8'h77);
        chk({st[1], pin_oe_n, pin_out}, 17'h00FA5);
        addr_strap <= 0;
        xfer(7'h21, 1'b0, expander_pkg::PTR_LATCH, 2'b11, 8'h00);
        chk({st[1], pin_out}, 9'h1A5);
        xfer(7'h20, 1'b0, 8'h07, 2'b11, 8'h12);
        chk({st[1], pin_oe_n, pin_out}, 17'h00FA5);
        addr_strap <= 1;
        rd(8'h00, 1'b0, 8'h07);
        presetn <= 0;
        @(posedge pclk);
        chk({alert_n, pin_oe_n, pin_out}, {1'b1, expander_pkg::DIR_RESET, expander_pkg::LATCH_RESET});
        presetn <= 1;
        repeat (10) @(posedge pclk);
        chk(alert_n, 1'b1);
        complete_run();
    end
endmodule
